// ==== core/dmr_mode_core.sv ====
// mode register zero, burst engines and power-down dll control
`timescale 1ns/1ps
module dmr_mode_core
   import dmr_pkg::*;
#(
   parameter int COL_W  = dmr_pkg::COL_W_DEF,
   parameter int DQ_W   = dmr_pkg::DQ_W_DEF,
   parameter int TMRD   = dmr_pkg::TMRD_CYC,
   parameter int TMOD   = dmr_pkg::TMOD_CYC,
   parameter int TDLLK  = dmr_pkg::TDLLK_CYC,
   parameter int TXP    = dmr_pkg::TXP_CYC,
   parameter int TXPDLL = dmr_pkg::TXPDLL_CYC
) (
   input  wire logic                          MCLK,
   input  wire logic                          RESETN,
   input  wire logic                          CKE,
   input  wire logic                          CS_N,
   input  wire logic                          RAS_N,
   input  wire logic                          CAS_N,
   input  wire logic                          WE_N,
   input  wire logic [dmr_pkg::BA_W-1:0]      BA,
   input  wire logic [dmr_pkg::ADDR_W-1:0]    A,
   input  wire logic [DQ_W-1:0]               DQ_IN,
   input  wire logic                          DQ_IN_VALID,
   output      logic                          DQ_IN_READY,
   output      logic [DQ_W-1:0]               DQ_OUT,
   output      logic                          DQ_OE,
   output      logic                          DQS_OE,
   output      logic [dmr_pkg::MR_W-1:0]      MODE_REG,
   output      logic                          MOD_BUSY,
   output      logic                          DLL_LOCKED,
   output      logic                          DLL_RUN,
   output      logic                          PD_ACTIVE,
   output      logic [3:0]                    CAS_LAT,
   output      logic [3:0]                    WR_CYC
);
   import dmr_pkg::*;

   typedef enum {RD_IDLE, RD_WAIT, RD_BURST} dmr_rd_t;
   typedef enum {WR_IDLE, WR_DATA} dmr_wr_t;

   // ----------------------------------------------------------------
   // command decode and write data fifo
   // ----------------------------------------------------------------
   dmr_cmd_t         cmd;
   logic             cmd_ok;
   logic [DQ_W-1:0]  mem [2**COL_W];
   dmr_stream_if #(.W(DQ_W)) in_if ();
   dmr_stream_if #(.W(DQ_W)) out_if ();
   assign in_if.valid = DQ_IN_VALID;
   assign in_if.data  = DQ_IN;
   assign DQ_IN_READY = in_if.ready;
   dmr_fifo #(.W(DQ_W), .DEPTH(FIFO_DEPTH)) dmr_fifo_inst (
      .clk(MCLK), .rst_n(RESETN), .in_s(in_if), .out_s(out_if)
   );

   // ----------------------------------------------------------------
   // mode register, command spacing, dll and power-down
   // ----------------------------------------------------------------
   logic [MR_W-1:0] mr0;
   logic [7:0]      mrd_cnt;
   logic [7:0]      mod_cnt;
   logic [9:0]      dll_cnt;
   logic [7:0]      xp_cnt;
   logic            pd;
   logic [MR_W-1:0] next_mr0;
   logic [7:0]      next_mrd_cnt;
   logic [7:0]      next_mod_cnt;
   logic [9:0]      next_dll_cnt;
   logic [7:0]      next_xp_cnt;
   logic            next_pd;
   logic            next_locked;
   logic            next_dll_run;
   logic            idle;
   assign cmd    = dmr_decode(CS_N, RAS_N, CAS_N, WE_N);
   // non-mode commands wait out tMOD and power-down exit; tMOD ends as the count reads one
   assign cmd_ok = CKE & ~pd & (mod_cnt <= 8'h01) & (xp_cnt == 8'h00);
   always_comb
   begin
      next_mr0     = mr0;
      next_mrd_cnt = (mrd_cnt != 8'h00) ? mrd_cnt - 8'h01 : mrd_cnt;
      next_mod_cnt = (mod_cnt != 8'h00) ? mod_cnt - 8'h01 : mod_cnt;
      next_dll_cnt = (dll_cnt != 10'h000) ? dll_cnt - 10'h001 : dll_cnt;
      next_xp_cnt  = (xp_cnt != 8'h00) ? xp_cnt - 8'h01 : xp_cnt;
      next_pd      = pd;
      next_locked  = DLL_LOCKED;
      // self-clear once the reset has been started
      if (mr0[DLL_RST_BIT])
      begin
         next_mr0[DLL_RST_BIT] = 1'b0;
         next_dll_cnt          = 10'(TDLLK);
         next_locked           = 1'b0;
      end
      else if (dll_cnt == 10'h001)
         next_locked = 1'b1;
      // whole register reloaded from bank and address bits
      if (cmd == CMD_MRS && CKE && !pd && mrd_cnt == 8'h00 && xp_cnt == 8'h00 &&
          BA == BA_MR0)
      begin
         next_mr0     = {BA[2], A};
         next_mrd_cnt = 8'(TMRD - 1);
         next_mod_cnt = 8'(TMOD);
      end
      // precharge power-down entry and exit
      if (!pd && !CKE && idle && mod_cnt == 8'h00)
         next_pd = 1'b1;
      else if (pd && CKE)
      begin
         next_pd     = 1'b0;
         next_xp_cnt = mr0[PPD_BIT] ? 8'(TXP - 1) : 8'(TXPDLL - 1);
      end
      next_dll_run = ~(next_pd & ~next_mr0[PPD_BIT]);
   end

   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         mr0        <= MR0_RESET;
         mrd_cnt    <= 8'h00;
         mod_cnt    <= 8'h00;
         dll_cnt    <= 10'h000;
         xp_cnt     <= 8'h00;
         pd         <= 1'b0;
         MODE_REG   <= MR0_RESET;
         MOD_BUSY   <= 1'b0;
         DLL_LOCKED <= 1'b0;
         DLL_RUN    <= 1'b1;
         PD_ACTIVE  <= 1'b0;
         CAS_LAT    <= 4'h5;
         WR_CYC     <= 4'hc;
      end
      else
      begin
         mr0        <= next_mr0;
         mrd_cnt    <= next_mrd_cnt;
         mod_cnt    <= next_mod_cnt;
         dll_cnt    <= next_dll_cnt;
         xp_cnt     <= next_xp_cnt;
         pd         <= next_pd;
         MODE_REG   <= next_mr0;
         MOD_BUSY   <= (next_mod_cnt != 8'h00);
         DLL_LOCKED <= next_locked;
         DLL_RUN    <= next_dll_run;
         PD_ACTIVE  <= next_pd;
         CAS_LAT    <= dmr_cas_lat(next_mr0[CL_LO+:3]);
         WR_CYC     <= dmr_wr_rec(next_mr0[WR_LO+:3]);
      end
   end

   // ----------------------------------------------------------------
   // burst length selection
   // ----------------------------------------------------------------
   logic cmd_chop;
   assign cmd_chop = (mr0[BL_LO+:2] == BL_CHOP4) |
                     ((mr0[BL_LO+:2] == BL_OTF) & ~A[BC_BIT]);

   // ----------------------------------------------------------------
   // read engine
   // ----------------------------------------------------------------
   dmr_rd_t          rd_state;
   logic [COL_W-1:0] rd_col;
   logic             rd_chop;
   logic [3:0]       rd_wait;
   logic [2:0]       rd_beat;
   dmr_rd_t          next_rd_state;
   logic [COL_W-1:0] next_rd_col;
   logic             next_rd_chop;
   logic [3:0]       next_rd_wait;
   logic [2:0]       next_rd_beat;
   logic [DQ_W-1:0]  next_dq;
   logic             next_oe;
   logic [COL_W-1:0] rd_addr;
   // block picked by upper bits, beat order inside it
   assign rd_addr = {rd_col[COL_W-1:3],
                     dmr_read_col(rd_col[2:0], rd_beat, mr0[BT_BIT])};
   always_comb
   begin
      next_rd_state = rd_state;
      next_rd_col   = rd_col;
      next_rd_chop  = rd_chop;
      next_rd_wait  = rd_wait;
      next_rd_beat  = rd_beat;
      next_dq       = DQ_OUT;
      next_oe       = 1'b0;
      unique case (rd_state)
         RD_IDLE:
         begin
            if (cmd == CMD_RD && cmd_ok)
            begin
               next_rd_col   = A[COL_W-1:0];
               next_rd_chop  = cmd_chop;
               next_rd_wait  = CAS_LAT - 4'h2;
               next_rd_beat  = 3'h0;
               next_rd_state = RD_WAIT;
            end
         end
         RD_WAIT:
         begin
            if (rd_wait == 4'h0)
               next_rd_state = RD_BURST;
            else
               next_rd_wait = rd_wait - 4'h1;
         end
         RD_BURST:
         begin
            // chopped burst keeps all eight slots, floats the last four
            next_dq      = mem[rd_addr];
            next_oe      = ~(rd_chop & rd_beat[2]);
            next_rd_beat = rd_beat + 3'h1;
            if (rd_beat == LAST_BEAT8)
               next_rd_state = RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         rd_state <= RD_IDLE;
         rd_col   <= '0;
         rd_chop  <= 1'b0;
         rd_wait  <= 4'h0;
         rd_beat  <= 3'h0;
         DQ_OUT   <= '0;
         DQ_OE    <= 1'b0;
         DQS_OE   <= 1'b0;
      end
      else
      begin
         rd_state <= next_rd_state;
         rd_col   <= next_rd_col;
         rd_chop  <= next_rd_chop;
         rd_wait  <= next_rd_wait;
         rd_beat  <= next_rd_beat;
         DQ_OUT   <= next_dq;
         DQ_OE    <= next_oe;
         DQS_OE   <= next_oe;
      end
   end

   // ----------------------------------------------------------------
   // write engine, drains the fifo into the array
   // ----------------------------------------------------------------
   dmr_wr_t            wr_state;
   logic [COL_W-1:0]   wr_col;
   logic               wr_chop;
   logic [2:0]         wr_beat;
   dmr_wr_t            next_wr_state;
   logic [COL_W-1:0]   next_wr_col;
   logic               next_wr_chop;
   logic [2:0]         next_wr_beat;
   logic               mem_we;
   logic [COL_W-1:0]   wr_addr;
   assign idle         = (rd_state == RD_IDLE) & (wr_state == WR_IDLE);
   assign out_if.ready = (wr_state == WR_DATA);
   assign mem_we       = out_if.valid & out_if.ready;
   // low start bits ignored; chop keeps the nibble from bit two
   assign wr_addr      = {wr_col[COL_W-1:3],
                          wr_chop ? {wr_col[2], wr_beat[1:0]} : wr_beat};
   always_comb
   begin
      next_wr_state = wr_state;
      next_wr_col   = wr_col;
      next_wr_chop  = wr_chop;
      next_wr_beat  = wr_beat;
      unique case (wr_state)
         WR_IDLE:
         begin
            if (cmd == CMD_WR && cmd_ok)
            begin
               next_wr_col   = A[COL_W-1:0];
               next_wr_chop  = cmd_chop;
               next_wr_beat  = 3'h0;
               next_wr_state = WR_DATA;
            end
         end
         WR_DATA:
         begin
            if (mem_we)
            begin
               next_wr_beat = wr_beat + 3'h1;
               if (wr_beat == (wr_chop ? LAST_BEAT4 : LAST_BEAT8))
                  next_wr_state = WR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         wr_state <= WR_IDLE;
         wr_col   <= '0;
         wr_chop  <= 1'b0;
         wr_beat  <= 3'h0;
      end
      else
      begin
         wr_state <= next_wr_state;
         wr_col   <= next_wr_col;
         wr_chop  <= next_wr_chop;
         wr_beat  <= next_wr_beat;
      end
   end
   always_ff @(posedge MCLK)
      if (mem_we)
         mem[wr_addr] <= out_if.data;
endmodule

// ==== core/dmr_pkg.sv ====
// constants, types and helper functions of the mode register zero logic
package dmr_pkg;

   // ----------------------------------------------------------------
   // mode register zero layout
   // ----------------------------------------------------------------
   localparam int          MR_W        = 17;
   localparam int          ADDR_W      = 16;
   localparam int          BA_W        = 3;
   localparam int          BL_LO       = 0;
   localparam int          BT_BIT      = 3;
   localparam int          CL_LO       = 4;
   localparam int          DLL_RST_BIT = 8;
   localparam int          WR_LO       = 9;
   localparam int          PPD_BIT     = 12;
   localparam logic [16:0] MR0_RESET   = 17'h00000;
   localparam logic [2:0]  BA_MR0      = 3'h0;
   localparam logic [1:0]  BL_FIX8     = 2'h0;
   localparam logic [1:0]  BL_OTF      = 2'h1;
   localparam logic [1:0]  BL_CHOP4    = 2'h2;

   // ----------------------------------------------------------------
   // command address bits and burst figures
   // ----------------------------------------------------------------
   localparam int          BC_BIT      = 12;
   localparam int          COL_W_DEF   = 6;
   localparam int          DQ_W_DEF    = 8;
   localparam int          FIFO_DEPTH  = 16;
   localparam logic [2:0]  LAST_BEAT8  = 3'h7;
   localparam logic [2:0]  LAST_BEAT4  = 3'h3;
   localparam logic [3:0]  CL_BASE     = 4'h4;

   // ----------------------------------------------------------------
   // clock period in ns and timing counts in MCLK cycles
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          TMRD_CYC    = 4;
   localparam int          TMOD_CYC    = 12;
   localparam int          TDLLK_CYC   = 512;
   localparam int          TXP_CYC     = 3;
   localparam int          TXPDLL_CYC  = 10;

   typedef enum {CMD_NOP, CMD_MRS, CMD_RD, CMD_WR, CMD_OTHER} dmr_cmd_t;

   function automatic dmr_cmd_t dmr_decode(input logic cs_n, input logic ras_n,
                                           input logic cas_n, input logic we_n);
      if (cs_n)
         return CMD_NOP;
      unique case ({ras_n, cas_n, we_n})
         3'h0:    return CMD_MRS;
         3'h5:    return CMD_RD;
         3'h4:    return CMD_WR;
         3'h7:    return CMD_NOP;
         default: return CMD_OTHER;
      endcase
   endfunction

   // read beat order inside an aligned block of eight columns
   function automatic logic [2:0] dmr_read_col(input logic [2:0] start,
                                               input logic [2:0] beat,
                                               input logic       ilv);
      if (ilv)
         return start ^ beat;
      return {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
   endfunction

   function automatic logic [3:0] dmr_cas_lat(input logic [2:0] f);
      return (f == 3'h0) ? 4'h5 : CL_BASE + {1'b0, f};
   endfunction

   function automatic logic [3:0] dmr_wr_rec(input logic [2:0] f);
      unique case (f)
         3'h1:    return 4'h5;
         3'h2:    return 4'h6;
         3'h3:    return 4'h7;
         3'h4:    return 4'h8;
         3'h5:    return 4'ha;
         default: return 4'hc;
      endcase
   endfunction

endpackage

// ==== core/dmr_stream_if.sv ====
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface dmr_stream_if #(parameter int W = 8);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== core/dmr_fifo.sv ====
// synchronous fifo with width and depth parameters
`timescale 1ns/1ps
module dmr_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic  clk,
   input  wire logic  rst_n,
   dmr_stream_if.snk  in_s,
   dmr_stream_if.src  out_s
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic [AW-1:0] next_wr_ptr;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0]   next_count;
   logic          push;
   logic          pop;

   assign in_s.ready  = (count != (AW+1)'(DEPTH));
   assign out_s.valid = (count != '0);
   assign out_s.data  = mem[rd_ptr];
   assign push        = in_s.valid & in_s.ready;
   assign pop         = out_s.valid & out_s.ready;

   always_comb
   begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop  ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr] <= in_s.data;
   end
endmodule

// ==== tb/dmr_mode_props.sv ====
// assertions on the ports of the mode register zero logic
`timescale 1ns/1ps
module dmr_mode_props
   import dmr_pkg::*;
#(
   parameter int TMOD  = 12,
   parameter int TDLLK = 512
) (
   input wire logic                       MCLK,
   input wire logic                       RESETN,
   input wire logic                       CKE,
   input wire logic                       CS_N,
   input wire logic                       RAS_N,
   input wire logic                       CAS_N,
   input wire logic                       WE_N,
   input wire logic [dmr_pkg::BA_W-1:0]   BA,
   input wire logic [dmr_pkg::ADDR_W-1:0] A,
   input wire logic                       DQ_OE,
   input wire logic                       DQS_OE,
   input wire logic [dmr_pkg::MR_W-1:0]   MODE_REG,
   input wire logic                       MOD_BUSY,
   input wire logic                       DLL_LOCKED,
   input wire logic                       DLL_RUN,
   input wire logic                       PD_ACTIVE
);
   logic       mrs_ok;
   logic [4:0] busy_n;
   logic [3:0] gap;
   logic [9:0] low_n;
   logic [4:0] next_busy_n;
   logic [3:0] next_gap;
   logic [9:0] next_low_n;

   // -------
   // cycles since mode set, power-down exit and dll unlock
   // -------
   always_comb
   begin
      mrs_ok = CKE && !CS_N && !RAS_N && !CAS_N && !WE_N && BA == BA_MR0 && !PD_ACTIVE
               && (!MOD_BUSY || busy_n >= 5'(TMRD_CYC - 1)) && gap == 4'hf;
      next_busy_n = mrs_ok ? 5'h0 : (MOD_BUSY ? busy_n + 5'h1 : 5'h0);
      next_gap = PD_ACTIVE ? 4'h0 : (gap == 4'hf ? gap : gap + 4'h1);
      // count restarts when a dll reset is started
      next_low_n = (DLL_LOCKED || MODE_REG[DLL_RST_BIT]) ? 10'h0 :
                   (low_n == 10'h3ff ? low_n : low_n + 10'h1);
   end

   always_ff @(posedge MCLK or negedge RESETN)
      if (!RESETN)
      begin
         busy_n <= 5'h0;
         gap <= 4'hf;
         low_n <= 10'h0;
      end
      else
      begin
         busy_n <= next_busy_n;
         gap <= next_gap;
         low_n <= next_low_n;
      end

   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   sequence s_mrs;
      mrs_ok;
   endsequence
   sequence s_burst8;
      DQ_OE [*8] ##1 !DQ_OE;
   endsequence
   sequence s_chop;
      DQ_OE [*4] ##1 !DQ_OE [*4];
   endsequence

   property p_mrs_load;
      s_mrs |=> MODE_REG[15:0] == $past(A);
   endproperty
   property p_mrs_busy;
      s_mrs |=> MOD_BUSY [*8];
   endproperty
   property p_busy_len;
      $fell(MOD_BUSY) |-> busy_n == 5'(TMOD);
   endproperty
   property p_dll_clr;
      $rose(MODE_REG[DLL_RST_BIT]) |=> !MODE_REG[DLL_RST_BIT];
   endproperty
   property p_dll_wait;
      $rose(DLL_LOCKED) |-> low_n >= 10'(TDLLK);
   endproperty
   property p_bl8;
      MODE_REG[1:0] == BL_FIX8 && $rose(DQ_OE) |-> s_burst8;
   endproperty
   property p_chop;
      MODE_REG[1:0] == BL_CHOP4 && $rose(DQ_OE) |-> s_chop;
   endproperty
   property p_dqs;
      DQS_OE == DQ_OE;
   endproperty
   property p_pd_dll;
      PD_ACTIVE && $past(PD_ACTIVE) |-> DLL_RUN == MODE_REG[PPD_BIT];
   endproperty

   a_mrs_load: assert property (p_mrs_load) else $error("mode set not loaded");
   a_mrs_busy: assert property (p_mrs_busy) else $error("busy missing");
   a_busy_len: assert property (p_busy_len) else $error("busy length");
   a_dll_clr: assert property (p_dll_clr) else $error("dll bit stuck");
   a_dll_wait: assert property (p_dll_wait) else $error("dll lock early");
   a_bl8: assert property (p_bl8) else $error("eight beat window");
   a_chop: assert property (p_chop) else $error("chop window");
   a_dqs: assert property (p_dqs) else $error("strobe enable");
   a_pd_dll: assert property (p_pd_dll) else $error("dll in power-down");
endmodule

bind dmr_mode_core dmr_mode_props #(.TMOD(TMOD), .TDLLK(TDLLK)) dmr_mode_props_inst (
   .MCLK(MCLK), .RESETN(RESETN), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
   .WE_N(WE_N), .BA(BA), .A(A), .DQ_OE(DQ_OE), .DQS_OE(DQS_OE), .MODE_REG(MODE_REG),
   .MOD_BUSY(MOD_BUSY), .DLL_LOCKED(DLL_LOCKED), .DLL_RUN(DLL_RUN), .PD_ACTIVE(PD_ACTIVE));

// ==== tb/dmr_ctrl_model.sv ====
// controller model issuing commands and write data
`timescale 1ns/1ps
module dmr_ctrl_model
   import dmr_pkg::*;
(
   input  wire logic                         MCLK,
   input  wire logic                         DQ_IN_READY,
   output      logic                         CKE,
   output      logic                         CS_N,
   output      logic                         RAS_N,
   output      logic                         CAS_N,
   output      logic                         WE_N,
   output      logic [dmr_pkg::BA_W-1:0]     BA,
   output      logic [dmr_pkg::ADDR_W-1:0]   A,
   output      logic [dmr_pkg::DQ_W_DEF-1:0] DQ_IN,
   output      logic                         DQ_IN_VALID
);
   initial
   begin
      CKE = 1'b1;
      {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
      BA = 3'h7;
      A = 16'h0;
      DQ_IN = 8'h0;
      DQ_IN_VALID = 1'b0;
   end

   // -------
   // one command edge, then deselect with lines turned over
   // -------
   task automatic cmd(input logic [2:0] rcw, input logic [2:0] b, input logic [15:0] a);
      @(negedge MCLK);
      {CS_N, RAS_N, CAS_N, WE_N} = {1'b0, rcw};
      BA = b;
      A = a;
      @(negedge MCLK);
      {CS_N, RAS_N, CAS_N, WE_N} = 4'hf;
      BA = ~b;
      A = ~a;
   endtask

   task automatic push(input logic [7:0] d);
      @(negedge MCLK);
      DQ_IN = d;
      DQ_IN_VALID = 1'b1;
      while (DQ_IN_READY !== 1'b1)
         @(negedge MCLK);
   endtask

   task automatic stop();
      @(negedge MCLK);
      DQ_IN_VALID = 1'b0;
      DQ_IN = ~DQ_IN;
   endtask

   task automatic set_cke(input logic v);
      @(negedge MCLK);
      CKE = v;
   endtask
endmodule

// ==== tb/test_ddr3_mode_register_mr0_logic.sv ====
// self-checking bench for the mode register zero logic
`timescale 1ns/1ps
module test_ddr3_mode_register_mr0_logic
   import dmr_pkg::*;
;
   logic        MCLK;
   logic        RESETN;
   wire logic   CKE, CS_N, RAS_N, CAS_N, WE_N, DQ_IN_VALID, DQ_IN_READY;
   wire logic   DQ_OE, DQS_OE, MOD_BUSY, DLL_LOCKED, DLL_RUN, PD_ACTIVE;
   wire logic [2:0]  BA;
   wire logic [15:0] A;
   wire logic [7:0]  DQ_IN, DQ_OUT;
   wire logic [16:0] MODE_REG;
   wire logic [3:0]  CAS_LAT, WR_CYC;
   int          fails = 0;
   int          n_checks = 0;

   dmr_mode_core #(.TDLLK(8)) dmr_mode_core_inst (
      .MCLK(MCLK), .RESETN(RESETN), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
      .WE_N(WE_N), .BA(BA), .A(A), .DQ_IN(DQ_IN), .DQ_IN_VALID(DQ_IN_VALID),
      .DQ_IN_READY(DQ_IN_READY), .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .DQS_OE(DQS_OE),
      .MODE_REG(MODE_REG), .MOD_BUSY(MOD_BUSY), .DLL_LOCKED(DLL_LOCKED), .DLL_RUN(DLL_RUN),
      .PD_ACTIVE(PD_ACTIVE), .CAS_LAT(CAS_LAT), .WR_CYC(WR_CYC));

   dmr_ctrl_model ctrl (
      .MCLK(MCLK), .DQ_IN_READY(DQ_IN_READY), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
      .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .A(A), .DQ_IN(DQ_IN), .DQ_IN_VALID(DQ_IN_VALID));

   initial
   begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end

   // -------
   // helpers
   // -------
   task automatic chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask

   function automatic logic [15:0] mr(input logic [1:0] bl, input logic bt, input logic [2:0] cl,
                                      input logic dll, input logic [2:0] wr, input logic pd);
      return {3'h0, pd, wr, dll, 1'b0, cl, bt, 1'b0, bl};
   endfunction

   task automatic mrs(input logic [2:0] b, input logic [15:0] a);
      ctrl.cmd(3'h0, b, a);
      repeat (13) @(negedge MCLK);
   endtask

   task automatic rd(input logic [5:0] col, input logic a12, input logic ilv, input int n);
      int i;
      logic [2:0] o;
      ctrl.cmd(3'h5, 3'h0, {3'h0, a12, 6'h0, col});
      for (i = 0; i < 20 && DQ_OE !== 1'b1; i++)
         @(negedge MCLK);
      // cl 5: first beat leaves on the fifth edge after the command edge
      chk(i == 5, "read latency");
      for (int k = 0; k < 8; k++)
      begin
         o = ilv ? col[2:0] ^ k[2:0] : {col[2] ^ k[2], 2'(col[1:0] + k[1:0])};
         if (k < n)
            chk(DQ_OE === 1'b1 && DQ_OUT === 8'h20 + {2'h0, col[5:3], o}, "read beat");
         else
            chk(DQ_OE === 1'b0 && DQS_OE === 1'b0, "slot not floating");
         @(negedge MCLK);
      end
   endtask

   // -------
   // scenarios
   // -------
   task automatic t_reset();
      chk(MODE_REG === 17'h0 && CAS_LAT === 4'h5 && WR_CYC === 4'hc, "reset regs");
      chk(DLL_RUN === 1'b1 && DQ_OE === 1'b0 && DQ_IN_READY === 1'b1, "reset pins");
   endtask

   task automatic t_mode_set();
      logic [15:0] v;
      v = mr(BL_FIX8, 1'b0, 3'h1, 1'b1, 3'h1, 1'b0);
      ctrl.cmd(3'h0, 3'h0, v);
      chk(MODE_REG[DLL_RST_BIT] === 1'b1 && MOD_BUSY === 1'b1, "mode set");
      @(negedge MCLK);
      chk(MODE_REG[DLL_RST_BIT] === 1'b0 && DLL_LOCKED === 1'b0, "dll reset");
      ctrl.cmd(3'h0, 3'h0, mr(BL_CHOP4, 1'b1, 3'h3, 1'b0, 3'h2, 1'b1));
      repeat (13) @(negedge MCLK);
      v[DLL_RST_BIT] = 1'b0;
      chk(MODE_REG === {1'b0, v} && DLL_LOCKED === 1'b1, "close mode set");
      mrs(3'h1, 16'h1e7b);
      chk(MODE_REG === {1'b0, v}, "other bank address");
   endtask

   task automatic t_decode();
      logic [3:0] w [8] = '{4'hc, 4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc, 4'hc};
      for (int f = 0; f < 8; f++)
      begin
         mrs(3'h0, mr(BL_FIX8, 1'b0, f[2:0], 1'b0, f[2:0], 1'b0));
         chk(CAS_LAT === (f == 0 ? 4'h5 : 4'(f + 4)) && WR_CYC === w[f], "decode");
      end
   endtask

   task automatic t_fill();
      for (int i = 0; i < 16; i++)
         ctrl.push(8'h20 + 8'(i));
      ctrl.stop();
      chk(DQ_IN_READY === 1'b0, "fifo full");
      ctrl.cmd(3'h4, 3'h0, 16'h0005);
      repeat (12) @(negedge MCLK);
      ctrl.cmd(3'h4, 3'h0, 16'h000d);
      repeat (12) @(negedge MCLK);
      chk(DQ_IN_READY === 1'b1, "fifo drained");
   endtask

   task automatic t_reads();
      mrs(3'h0, mr(BL_FIX8, 1'b0, 3'h1, 1'b0, 3'h1, 1'b0));
      rd(6'h01, 1'b1, 1'b0, 8);
      mrs(3'h0, mr(BL_FIX8, 1'b1, 3'h1, 1'b0, 3'h1, 1'b0));
      rd(6'h0d, 1'b1, 1'b1, 8);
      mrs(3'h0, mr(BL_CHOP4, 1'b0, 3'h1, 1'b0, 3'h1, 1'b0));
      rd(6'h06, 1'b1, 1'b0, 4);
      mrs(3'h0, mr(BL_OTF, 1'b0, 3'h1, 1'b0, 3'h1, 1'b0));
      rd(6'h0b, 1'b1, 1'b0, 8);
      rd(6'h0b, 1'b0, 1'b0, 4);
   endtask

   task automatic t_pd();
      for (int p = 0; p < 2; p++)
      begin
         mrs(3'h0, mr(BL_FIX8, 1'b0, 3'h1, 1'b0, 3'h1, p[0]));
         ctrl.set_cke(1'b0);
         repeat (3) @(negedge MCLK);
         chk(PD_ACTIVE === 1'b1 && DLL_RUN === p[0], "power-down dll");
         ctrl.set_cke(1'b1);
         repeat (12) @(negedge MCLK);
         chk(PD_ACTIVE === 1'b0 && DLL_RUN === 1'b1, "power-down exit");
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      RESETN = 1'b0;
      repeat (12) @(negedge MCLK);
      RESETN = 1'b1;
      t_reset();
      t_mode_set();
      t_decode();
      t_fill();
      t_reads();
      t_pd();
      close_out();
   end

   initial
   begin
      #75000;
      fails++;
      close_out();
   end
endmodule
